// file: src/lcf_regs.sv
/*
  Link control and frequency register bank, AXI4-Lite slave, top module.
  Assumes link pins arrive asynchronously; all but link_present and link_unused pass two flops here.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module lcf_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_good,
  input wire logic link_stop_n,
  input wire logic link_clk,
  input wire logic [1:0] init_done_pin,
  input wire logic [1:0] link_present,
  input wire logic [1:0] link_unused,
  input wire logic [1:0] crc_err_a,
  input wire logic crc_err_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] tx_float,
  output logic [1:0] rx_powerdown,
  output logic [1:0] tx_enable,
  output logic [1:0] rx_enable,
  output logic [1:0] crc_corrupt,
  output logic [1:0] drop_or_nxa,
  output logic [1:0] nop_only,
  output logic [1:0] crc_check_en,
  output logic [1:0] sync_flood,
  output logic [3:0] side_a_operating_freq,
  output logic link_clk_rise
);
  import lcf_pkg::*;
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] sy1_q, sy2_q;
  logic pg_q, lclk_d1_q;
  always_ff @(posedge aclk) begin
    sy1_q <= {power_good, link_stop_n, link_clk, init_done_pin, crc_err_a, crc_err_b};
    sy2_q <= sy1_q;
    lclk_d1_q <= sy2_q[5];
    pg_q <= sy2_q[7];
  end
  wire pg_s = sy2_q[7];
  wire stop_s = sy2_q[6];
  wire [1:0] init_s = sy2_q[4:3];
  wire [1:0] crca_s = sy2_q[2:1];
  wire crcb_s = sy2_q[0];
  assign link_clk_rise = sy2_q[5] && !lclk_d1_q;
  wire power_good_q = pg_q && pg_s;
  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  wire do_write = aw_held_q && w_held_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end
  function automatic logic is_mapped(input logic [7:0] a);
    return {a[7:2], 2'b00} == LCF_LINK_A_CONTROL_OFS
      || {a[7:2], 2'b00} == LCF_LINK_B_CONTROL_OFS
      || {a[7:2], 2'b00} == LCF_LINK_A_FREQ_CAP_OFS;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LCF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(awaddr_q) ? LCF_RESP_OKAY : LCF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  wire [7:0] wa = {awaddr_q[7:2], 2'b00};
  wire wr_a = do_write && wa == LCF_LINK_A_CONTROL_OFS;
  wire wr_b = do_write && wa == LCF_LINK_B_CONTROL_OFS;
  wire wr_cap = do_write && wa == LCF_LINK_A_FREQ_CAP_OFS;
  // ------------------------------------------------------------
  // link sides
  // ------------------------------------------------------------
  logic [31:0] ctl_a, ctl_b;
  logic [1:0] flood_ev, disc_done;
  lcf_link_side #(.WIDE(1'b1)) u_side_a (
    .aclk(aclk), .power_good_q(power_good_q), .rst_n(aresetn), .stop_n(stop_s),
    .init_done(init_s[0]), .link_present(link_present[0]), .link_unused(link_unused[0]),
    .crc_err_byte(crca_s), .wr_ctl(wr_a), .wdata(wdata_q), .wstrb(wstrb_q),
    .ctl_rdata(ctl_a), .flood_event(flood_ev[0]), .disc_done(disc_done[0]),
    .tx_float(tx_float[0]), .rx_powerdown(rx_powerdown[0]), .tx_enable(tx_enable[0]),
    .rx_enable(rx_enable[0]), .crc_corrupt(crc_corrupt[0]), .drop_or_nxa(drop_or_nxa[0]),
    .nop_only(nop_only[0]), .crc_check_en(crc_check_en[0])
  );
  // side b is the narrow link: no upper-byte crc flag
  lcf_link_side #(.WIDE(1'b0)) u_side_b (
    .aclk(aclk), .power_good_q(power_good_q), .rst_n(aresetn), .stop_n(stop_s),
    .init_done(init_s[1]), .link_present(link_present[1]), .link_unused(link_unused[1]),
    .crc_err_byte({1'b0, crcb_s}), .wr_ctl(wr_b), .wdata(wdata_q), .wstrb(wstrb_q),
    .ctl_rdata(ctl_b), .flood_event(flood_ev[1]), .disc_done(disc_done[1]),
    .tx_float(tx_float[1]), .rx_powerdown(rx_powerdown[1]), .tx_enable(tx_enable[1]),
    .rx_enable(rx_enable[1]), .crc_corrupt(crc_corrupt[1]), .drop_or_nxa(drop_or_nxa[1]),
    .nop_only(nop_only[1]), .crc_check_en(crc_check_en[1])
  );
  // either side's flood error syncs both outgoing links
  assign sync_flood = {2{|flood_ev}};
  // ------------------------------------------------------------
  // side a frequency
  // ------------------------------------------------------------
  logic [3:0] freq_q, op_freq_q;
  function automatic logic freq_legal(input logic [3:0] f);
    return f == LCF_FREQ_200 || f == LCF_FREQ_400 || f == LCF_FREQ_600 || f == LCF_FREQ_800;
  endfunction
  wire [3:0] wfreq = wdata_q[LCF_FREQ_LSB+3:LCF_FREQ_LSB];
  always_ff @(posedge aclk) begin
    if (!power_good_q) begin
      freq_q <= LCF_FREQ_CAP_RESET[LCF_FREQ_LSB+3:LCF_FREQ_LSB];
    end else if (wr_cap && wstrb_q[1] && freq_legal(wfreq)) begin
      freq_q <= wfreq;
    end
  end
  // new frequency only takes effect in reset or after a disconnect
  always_ff @(posedge aclk) begin
    if (!power_good_q || !aresetn || disc_done[0]) begin
      op_freq_q <= freq_q;
    end
  end
  assign side_a_operating_freq = op_freq_q;
  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  logic [31:0] cap_rd;
  always_comb begin
    cap_rd = 32'h0000_0000;
    cap_rd[LCF_CAP_LSB+15:LCF_CAP_LSB] = LCF_SIDE_A_FREQ_CAP;
    cap_rd[LCF_FREQ_LSB+3:LCF_FREQ_LSB] = freq_q;
    cap_rd[7:0] = LCF_PROTOCOL_REV;
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= LCF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? LCF_RESP_OKAY : LCF_RESP_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        LCF_LINK_A_CONTROL_OFS: s_axi_rdata <= ctl_a;
        LCF_LINK_B_CONTROL_OFS: s_axi_rdata <= ctl_b;
        LCF_LINK_A_FREQ_CAP_OFS: s_axi_rdata <= cap_rd;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_freq_legal;
    @(posedge aclk) disable iff (!power_good_q || !aresetn) freq_legal(freq_q);
  endproperty
  a_freq_legal: assert property (p_freq_legal) else $error("illegal frequency code");
  property p_freq_hold;
    @(posedge aclk) disable iff (!aresetn)
      ($stable(op_freq_q) || $past(disc_done[0]) || !$past(power_good_q));
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("frequency changed early");
  // look at the returned word, not the constant behind it
  property p_cap_read;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready
        && {s_axi_araddr[7:2], 2'b00} == LCF_LINK_A_FREQ_CAP_OFS)
      |=> s_axi_rdata[31:16] == LCF_SIDE_A_FREQ_CAP && s_axi_rdata[7:0] == LCF_PROTOCOL_REV;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability wrong");
  property p_bresp;
    @(posedge aclk) disable iff (!aresetn) do_write |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");
  property p_flood_both;
    @(posedge aclk) disable iff (!power_good_q || !aresetn)
      flood_ev[0] |-> (sync_flood == 2'b11) ##1 ctl_a[LCF_FAIL_BIT];
  endproperty
  a_flood_both: assert property (p_flood_both) else $error("flood not on both");
  property p_eoc_nop;
    @(posedge aclk) drop_or_nxa[0] |-> !crc_check_en[0];
  endproperty
  a_eoc_nop: assert property (p_eoc_nop) else $error("crc checked at end of chain");
  property p_transmitter_off;
    @(posedge aclk) !tx_enable[0] |-> tx_float[0] && !rx_enable[0];
  endproperty
  a_transmitter_off: assert property (p_transmitter_off) else $error("tx off not silent");
  property p_init_rst;
    @(posedge aclk) disable iff (!power_good_q) !aresetn |=> !ctl_a[LCF_INIT_BIT];
  endproperty
  a_init_rst: assert property (p_init_rst) else $error("init survived reset");
  // ------------------------------------------------------------
  // link side checks
  // ------------------------------------------------------------
  property p_crc_set;
    @(posedge aclk) disable iff (!power_good_q || !aresetn)
      ((|crca_s) && crc_check_en[0])
      |=> ((ctl_a[LCF_CRC_HI_BIT:LCF_CRC_LO_BIT] & $past(crca_s)) == $past(crca_s));
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("crc flag not set");
  property p_crc_narrow;
    @(posedge aclk) disable iff (!power_good_q || !aresetn) !ctl_b[LCF_CRC_HI_BIT];
  endproperty
  a_crc_narrow: assert property (p_crc_narrow) else $error("upper crc flag on side b");
  property p_fail_unused;
    @(posedge aclk) disable iff (!power_good_q) link_unused[1] |=> ctl_b[LCF_FAIL_BIT];
  endproperty
  a_fail_unused: assert property (p_fail_unused) else $error("unused link not failed");
  // software-only field, so nothing may move it across an ordinary reset
  property p_sticky_rst;
    @(posedge aclk) (power_good_q && $fell(aresetn)) |=> $stable(ctl_a[LCF_TRISTATE_BIT]);
  endproperty
  a_sticky_rst: assert property (p_sticky_rst) else $error("sticky field lost");
  property p_eoc_hw;
    @(posedge aclk) disable iff (!power_good_q)
      (aresetn && !$past(aresetn) && !link_present[1]) |=> ctl_b[LCF_EOC_BIT];
  endproperty
  a_eoc_hw: assert property (p_eoc_hw) else $error("end of chain not set");
  property p_init_stop;
    @(posedge aclk) disable iff (!aresetn) disc_done[0] |=> !ctl_a[LCF_INIT_BIT];
  endproperty
  a_init_stop: assert property (p_init_stop) else $error("init survived stop");
  property p_float;
    @(posedge aclk) disable iff (!power_good_q || !aresetn)
      (disc_done[0] && ctl_a[LCF_TRISTATE_BIT]) |-> (tx_float[0] && rx_powerdown[0]);
  endproperty
  a_float: assert property (p_float) else $error("link not floated");
  property p_driven;
    @(posedge aclk) disable iff (!power_good_q || !aresetn)
      (disc_done[1] && !ctl_b[LCF_TRISTATE_BIT] && !ctl_b[LCF_TX_OFF_BIT])
      |-> (!tx_float[1] && !rx_powerdown[1]);
  endproperty
  a_driven: assert property (p_driven) else $error("link not driven");
  c_write: cover property (@(posedge aclk) wr_a);
  c_flood: cover property (@(posedge aclk) |flood_ev);
  c_freq: cover property (@(posedge aclk) wr_cap ##[1:20] disc_done[0]);
  c_eoc_hw: cover property (@(posedge aclk) $rose(ctl_b[LCF_EOC_BIT]));
  c_stop: cover property (@(posedge aclk) disc_done[0] && tx_float[0]);
endmodule

// file: src/lcf_pkg.sv
/*
  Package for the link control and frequency register bank: offsets,
  field positions, reset values and encodings.
  Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
*/
package lcf_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] LCF_LINK_A_CONTROL_OFS = 8'hC4;
  localparam logic [7:0] LCF_LINK_B_CONTROL_OFS = 8'hC8;
  localparam logic [7:0] LCF_LINK_A_FREQ_CAP_OFS = 8'hCC;
  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int LCF_TRISTATE_BIT = 13;
  localparam int LCF_CRC_HI_BIT = 9;
  localparam int LCF_CRC_LO_BIT = 8;
  localparam int LCF_TX_OFF_BIT = 7;
  localparam int LCF_EOC_BIT = 6;
  localparam int LCF_INIT_BIT = 5;
  localparam int LCF_FAIL_BIT = 4;
  localparam int LCF_INJECT_BIT = 3;
  localparam int LCF_FLOOD_BIT = 1;
  // ------------------------------------------------------------
  // frequency capability register
  // ------------------------------------------------------------
  localparam int LCF_FREQ_LSB = 8;
  localparam int LCF_CAP_LSB = 16;
  localparam logic [31:0] LCF_FREQ_CAP_RESET = 32'h0035_0022;
  localparam logic [15:0] LCF_SIDE_A_FREQ_CAP = 16'h0035;
  localparam logic [7:0] LCF_PROTOCOL_REV = 8'h22;
  localparam logic [3:0] LCF_FREQ_200 = 4'h0;
  localparam logic [3:0] LCF_FREQ_400 = 4'h2;
  localparam logic [3:0] LCF_FREQ_600 = 4'h4;
  localparam logic [3:0] LCF_FREQ_800 = 4'h5;
  localparam logic [1:0] LCF_RESP_OKAY = 2'h0;
  localparam logic [1:0] LCF_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LCF_LINK_RUN, LCF_LINK_STOPPING, LCF_LINK_STOPPED} lcf_link_type;
endpackage

// file: src/lcf_link_side.sv
/*
  Per-link control logic: sticky flags, disconnect handling, init status.
  Assumes stop_n, rst_n and init_done are already in the aclk domain.
*/
`timescale 1ns/1ps
module lcf_link_side #(
  parameter bit WIDE = 1'b1
) (
  input wire logic aclk,
  input wire logic power_good_q,
  input wire logic rst_n,
  input wire logic stop_n,
  input wire logic init_done,
  input wire logic link_present,
  input wire logic link_unused,
  input wire logic [1:0] crc_err_byte,
  input wire logic wr_ctl,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic [31:0] ctl_rdata,
  output logic flood_event,
  output logic disc_done,
  output logic tx_float,
  output logic rx_powerdown,
  output logic tx_enable,
  output logic rx_enable,
  output logic crc_corrupt,
  output logic drop_or_nxa,
  output logic nop_only,
  output logic crc_check_en
);
  import lcf_pkg::*;
  logic tristate_q, tx_off_q, eoc_q, init_q, fail_q, inject_q, flood_q;
  logic [1:0] crc_q;
  logic rst_n_q;
  lcf_link_type lst_q;
  logic [1:0] crc_seen;
  logic w1, w0;
  assign w1 = wr_ctl && wstrb[1];
  assign w0 = wr_ctl && wstrb[0];
  // events only count while crc is being checked
  assign crc_seen = (eoc_q || tx_off_q) ? 2'b00 : (crc_err_byte & {WIDE, 1'b1});
  // ------------------------------------------------------------
  // sticky fields: power_good clears them, ordinary reset does not
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!power_good_q) begin
      tristate_q <= 1'b0;
      crc_q <= 2'b00;
      fail_q <= 1'b0;
    end else begin
      if (w1) begin
        tristate_q <= wdata[LCF_TRISTATE_BIT];
      end
      // set wins over a one-to-clear in the same cycle
      crc_q <= (crc_q & ~({2{w1}} & wdata[LCF_CRC_HI_BIT:LCF_CRC_LO_BIT])) | crc_seen;
      fail_q <= (fail_q & ~(w0 && wdata[LCF_FAIL_BIT]))
        | ((|crc_seen) && flood_q) | link_unused;
    end
  end
  // ------------------------------------------------------------
  // ordinary-reset fields
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!power_good_q || !rst_n) begin
      tx_off_q <= 1'b0;
      inject_q <= 1'b0;
      flood_q <= 1'b0;
    end else if (w0) begin
      tx_off_q <= tx_off_q | wdata[LCF_TX_OFF_BIT];
      inject_q <= wdata[LCF_INJECT_BIT];
      flood_q <= wdata[LCF_FLOOD_BIT];
    end
  end
  always_ff @(posedge aclk) begin
    rst_n_q <= rst_n;
    if (!power_good_q) begin
      eoc_q <= 1'b0;
    end else if (rst_n && !rst_n_q && !link_present) begin
      eoc_q <= 1'b1;
    end else if (w0 && wdata[LCF_EOC_BIT]) begin
      eoc_q <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // disconnect sequence and init status
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      lst_q <= LCF_LINK_RUN;
    end else begin
      unique case (lst_q)
        LCF_LINK_RUN: if (!stop_n) lst_q <= LCF_LINK_STOPPING;
        LCF_LINK_STOPPING: lst_q <= LCF_LINK_STOPPED;
        LCF_LINK_STOPPED: if (stop_n) lst_q <= LCF_LINK_RUN;
      endcase
    end
  end
  assign disc_done = (lst_q == LCF_LINK_STOPPING);
  always_ff @(posedge aclk) begin
    if (!rst_n || disc_done) begin
      init_q <= 1'b0;
    end else if (init_done && link_present && lst_q == LCF_LINK_RUN) begin
      init_q <= 1'b1;
    end
  end
  wire stopped = (lst_q != LCF_LINK_RUN);
  assign tx_float = (stopped && tristate_q) || tx_off_q;
  assign rx_powerdown = (stopped && tristate_q) || tx_off_q;
  assign tx_enable = !tx_off_q;
  assign rx_enable = !tx_off_q;
  assign crc_corrupt = inject_q && !eoc_q;
  assign drop_or_nxa = eoc_q;
  assign nop_only = eoc_q && !tx_off_q;
  assign crc_check_en = !eoc_q && !tx_off_q;
  assign flood_event = (|crc_seen) && flood_q;
  always_comb begin
    ctl_rdata = 32'h0000_0000;
    ctl_rdata[LCF_TRISTATE_BIT] = tristate_q;
    ctl_rdata[LCF_CRC_HI_BIT:LCF_CRC_LO_BIT] = crc_q;
    ctl_rdata[LCF_TX_OFF_BIT] = tx_off_q;
    ctl_rdata[LCF_EOC_BIT] = eoc_q;
    ctl_rdata[LCF_INIT_BIT] = init_q;
    ctl_rdata[LCF_FAIL_BIT] = fail_q;
    ctl_rdata[LCF_INJECT_BIT] = inject_q;
    ctl_rdata[LCF_FLOOD_BIT] = flood_q;
  end
endmodule

// file: dv/lcf_link_partner.sv
/*
  Far-side link device model: link clock, init handshake, crc error events.
  Assumes the bench drives run and err_go just after rising aclk edges.
*/
`timescale 1ns/1ps
module lcf_link_partner (
  input wire logic aclk,
  input wire logic run,
  input wire logic [2:0] err_sel,
  input wire logic err_go,
  output logic link_clk,
  output logic [1:0] init_done_pin,
  output logic [1:0] crc_err_a,
  output logic crc_err_b
);
  // ------------------------------------------------------------
  // link clock and init
  // ------------------------------------------------------------
  int rises = 0;
  // clock stands still low outside frames
  initial begin
    link_clk = 1'b0;
    forever begin
      #80;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  always @(posedge link_clk or negedge run) begin
    if (!run) begin
      rises <= 0;
    end else begin
      rises <= rises + 1;
    end
  end
  // side a answers promptly, side b slowly
  assign init_done_pin = {rises >= 8, rises >= 2};
  // ------------------------------------------------------------
  // crc error events, idle low
  // ------------------------------------------------------------
  initial crc_err_a = 2'h0;
  initial crc_err_b = 1'b0;
  always @(posedge aclk) begin
    crc_err_a <= err_go ? err_sel[1:0] : 2'h0;
    crc_err_b <= err_go & err_sel[2];
  end
endmodule

// file: dv/test_link_control_freq_regs.sv
/*
  Self-checking bench for the link control and frequency register bank.
  Assumes the lcf_regs top and lcf_link_partner as the far side.
*/
`timescale 1ns/1ps
module test_link_control_freq_regs;
  import lcf_pkg::*;
  localparam logic [7:0] A_OFS = LCF_LINK_A_CONTROL_OFS;
  localparam logic [7:0] B_OFS = LCF_LINK_B_CONTROL_OFS;
  localparam logic [7:0] C_OFS = LCF_LINK_A_FREQ_CAP_OFS;
  logic aclk = 0, aresetn = 0, power_good = 0, link_stop_n = 1, run = 0, err_go = 0;
  logic [2:0] err_sel = 0;
  logic [1:0] link_present = 2'h3, link_unused = 2'h0, init_done_pin, crc_err_a;
  logic crc_err_b, link_clk, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, seed = 32'd88225, d;
  logic [1:0] bresp, rresp, tx_float, rx_powerdown, tx_enable, rx_enable, crc_corrupt;
  logic [1:0] drop_or_nxa, nop_only, crc_check_en, sync_flood;
  logic [3:0] side_a_operating_freq, exp_f = 4'h0;
  int miscompares = 0, comparisons = 0, cycles = 0, flood_seen = 0;
  int lk_rises = 0, lk_seen = 0;
  logic [3:0] wstrb = 4'hF;
  logic link_clk_rise;
  lcf_regs DUT (.aclk(aclk), .aresetn(aresetn), .power_good(power_good),
    .link_stop_n(link_stop_n), .link_clk(link_clk), .init_done_pin(init_done_pin),
    .link_present(link_present), .link_unused(link_unused), .crc_err_a(crc_err_a),
    .crc_err_b(crc_err_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_float(tx_float), .rx_powerdown(rx_powerdown), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .crc_corrupt(crc_corrupt), .drop_or_nxa(drop_or_nxa),
    .nop_only(nop_only), .crc_check_en(crc_check_en), .sync_flood(sync_flood),
    .side_a_operating_freq(side_a_operating_freq), .link_clk_rise(link_clk_rise));
  lcf_link_partner partner (.aclk(aclk), .run(run & link_stop_n), .err_sel(err_sel),
    .err_go(err_go), .link_clk(link_clk), .init_done_pin(init_done_pin),
    .crc_err_a(crc_err_a), .crc_err_b(crc_err_b));
  // ------------------------------------------------------------
  // clock, timeout, flood monitor
  // ------------------------------------------------------------
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge link_clk) lk_rises++;
  always @(posedge aclk) begin
    cycles++;
    if (sync_flood === 2'h3) flood_seen++;
    if (link_clk_rise === 1'b1) lk_seen++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task wrap_up();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(a, v, r);
    chk(v, e, "rdata");
    chk({30'h0, r}, {30'h0, er}, "rresp");
  endtask
  task wait_init(input logic [7:0] a);
    logic [31:0] v;
    logic [1:0] r;
    int k;
    v = 0;
    for (k = 0; k < 40 && v[5] !== 1'b1; k++) axi_rd(a, v, r);
    chk({31'h0, v[5]}, 32'h1, "init complete");
  endtask
  task crc_hit(input logic [2:0] sel);
    err_sel <= sel;
    err_go <= 1'b1;
    repeat (2) @(posedge aclk);
    err_go <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    power_good <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(C_OFS, 32'h0035_0022);
    rd_chk(A_OFS, 32'h0);
    rd_chk(B_OFS, 32'h0);
    axi_wr(8'h40, 32'hFFFF_FFFF, 2'h2);
    rd_chk(8'h40, 32'h0, 2'h2);
    // fixed codes first, then random words
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      d = seed;
      if (i < 4) d[11:8] = 4'(i == 0 ? 0 : i + i + (i == 3 ? -1 : 0));
      if (d[11:8] inside {4'h0, 4'h2, 4'h4, 4'h5}) exp_f = d[11:8];
      axi_wr(C_OFS, d);
      rd_chk(C_OFS, {16'h0035, 4'h0, exp_f, 8'h22});
    end
    chk({28'h0, side_a_operating_freq}, 32'h0, "freq early");
    axi_wr(A_OFS, 32'h0000_200A);
    axi_wr(B_OFS, 32'h0);
    rd_chk(A_OFS, 32'h0000_200A);
    chk({30'h0, crc_corrupt}, 32'h1, "inject");
    run <= 1'b1;
    wait_init(A_OFS);
    wait_init(B_OFS);
    crc_hit(3'h3);
    chk({31'h0, flood_seen != 0}, 32'h1, "flood a");
    rd_chk(A_OFS, 32'h0000_233A);
    flood_seen = 0;
    crc_hit(3'h4);
    rd_chk(B_OFS, 32'h0000_0120);
    chk(flood_seen, 32'h0, "flood b");
    axi_wr(A_OFS, 32'h0000_200A);
    rd_chk(A_OFS, 32'h0000_233A);
    axi_wr(A_OFS, 32'h0000_231A);
    rd_chk(A_OFS, 32'h0000_202A);
    link_unused <= 2'h2;
    repeat (5) @(posedge aclk);
    link_unused <= 2'h0;
    repeat (4) @(posedge aclk);
    rd_chk(B_OFS, 32'h0000_0130);
    axi_wr(B_OFS, 32'h0000_0110);
    rd_chk(B_OFS, 32'h0000_0020);
    link_stop_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({tx_float, rx_powerdown}, 32'h5, "float");
    chk(lk_seen, lk_rises, "link clock rises");
    rd_chk(A_OFS, 32'h0000_200A);
    link_stop_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({28'h0, side_a_operating_freq}, {28'h0, exp_f}, "freq load");
    run <= 1'b0;
    link_present <= 2'h1;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    link_present <= 2'h3;
    rd_chk(A_OFS, 32'h0000_2000);
    rd_chk(B_OFS, 32'h0000_0040);
    chk({drop_or_nxa[1], nop_only[1], crc_check_en[1]}, 32'h6, "eoc");
    axi_wr(A_OFS, 32'h0000_2080);
    axi_wr(A_OFS, 32'h0000_2000);
    rd_chk(A_OFS, 32'h0000_2080);
    chk({tx_enable[0], rx_enable[0]}, 32'h0, "tx off");
    wstrb <= 4'h1;
    axi_wr(A_OFS, 32'h0000_0008);
    wstrb <= 4'hF;
    rd_chk(A_OFS, 32'h0000_2088);
    aresetn <= 1'b0;
    power_good <= 1'b0;
    repeat (6) @(posedge aclk);
    power_good <= 1'b1;
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(A_OFS, 32'h0);
    rd_chk(C_OFS, 32'h0035_0022);
    wrap_up();
  end
endmodule
